// *** rtl/rate_source_pkg.sv ***
package rate_source_pkg;

  localparam int unsigned DATA_W      = 8;
  localparam int unsigned ADDR_W      = 4;
  localparam int unsigned PSEL_W      = 3;
  localparam int unsigned PRE_W       = 8;
  localparam int unsigned SERIAL_DIV  = 32;
  localparam int unsigned FRAME_DIV_A = 128;
  localparam int unsigned FRAME_DIV_B = 256;
  localparam int unsigned FDIV_W      = 9;

  // Register word indices on the plain register port.
  localparam logic [ADDR_W-1:0] REG_S0_PSEL   = 4'h0;
  localparam logic [ADDR_W-1:0] REG_S0_RELOAD = 4'h1;
  localparam logic [ADDR_W-1:0] REG_S0_CMP    = 4'h2;
  localparam logic [ADDR_W-1:0] REG_S1_PSEL   = 4'h3;
  localparam logic [ADDR_W-1:0] REG_S1_RELOAD = 4'h4;
  localparam logic [ADDR_W-1:0] REG_S1_CMP    = 4'h5;
  localparam logic [ADDR_W-1:0] REG_LCD_PSEL  = 4'h6;
  localparam logic [ADDR_W-1:0] REG_LCD_RELOAD = 4'h7;
  localparam logic [ADDR_W-1:0] REG_LCD_CMP   = 4'h8;
  localparam logic [ADDR_W-1:0] REG_LCD_DUTY  = 4'h9;
  localparam logic [ADDR_W-1:0] REG_STATUS    = 4'hA;

  localparam logic [DATA_W-1:0] RESET_VAL = 8'h00;
  localparam int unsigned       STAT_S0_BIT  = 0;
  localparam int unsigned       STAT_S1_BIT  = 1;
  localparam int unsigned       STAT_LCD_BIT = 2;

  typedef enum logic [1:0] {
    DUTY_1_16,
    DUTY_1_3,
    DUTY_1_8
  } lcd_duty_t;

  typedef struct packed {
    logic [PSEL_W-1:0] prescale_sel;
    logic [DATA_W-1:0] reload_value;
    logic [DATA_W-1:0] compare_value;
  } timer_cfg_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } reg_req_t;

endpackage : rate_source_pkg

// *** rtl/underflow_timer.sv ***
module underflow_timer
  import rate_source_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire timer_cfg_t cfg,
  output logic            underflow
);

  typedef struct packed {
    logic [PRE_W-1:0]  pre;
    logic [DATA_W-1:0] count;
    logic              uf;
  } tstate_t;

  tstate_t s_q;
  tstate_t s_d;
  logic    tick;

  always_comb begin
    s_d      = s_q;
    s_d.pre  = s_q.pre + PRE_W'(1);
    tick     = &(s_q.pre | ~((PRE_W'(1) << cfg.prescale_sel) - PRE_W'(1)));
    s_d.uf   = 1'b0;
    if (tick) begin
      if (s_q.count == '0) begin
        s_d.count = cfg.reload_value;
        s_d.uf    = 1'b1;
      end else begin
        s_d.count = s_q.count - DATA_W'(1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign underflow = s_q.uf;

endmodule : underflow_timer

// *** rtl/timer_rate_source.sv ***
module timer_rate_source
  import rate_source_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output logic      [DATA_W-1:0] rdata,
  output logic                   serial0_tick,
  output logic                   serial1_tick,
  output logic                   serial0_bit_clk,
  output logic                   serial1_bit_clk,
  output logic                   lcd_src_tick,
  output logic                   lcd_frame_freq
);

  typedef struct packed {
    timer_cfg_t        s0;
    timer_cfg_t        s1;
    timer_cfg_t        lcd;
    lcd_duty_t         duty;
    logic [DATA_W-1:0] rdata;
    logic [4:0]        s0_div;
    logic [4:0]        s1_div;
    logic [FDIV_W-1:0] f_div;
    logic              s0_uf;
    logic              s1_uf;
    logic              lcd_uf;
    logic              s0_clk;
    logic              s1_clk;
    logic              frame;
  } state_t;

  state_t   s_q;
  state_t   s_d;
  reg_req_t req;
  logic     uf0;
  logic     uf1;
  logic     ufl;
  logic [FDIV_W-1:0] fhalf;

  assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

  underflow_timer u_s0 (.clk(clk), .reset(reset), .cfg(s_q.s0), .underflow(uf0));
  underflow_timer u_s1 (.clk(clk), .reset(reset), .cfg(s_q.s1), .underflow(uf1));
  underflow_timer u_lcd (.clk(clk), .reset(reset), .cfg(s_q.lcd), .underflow(ufl));

  always_comb begin
    s_d        = s_q;
    s_d.s0_uf  = uf0;
    s_d.s1_uf  = uf1;
    s_d.lcd_uf = ufl;
    s_d.rdata  = RESET_VAL;
    if (req.wr) begin
      unique case (req.addr)
        REG_S0_PSEL:    s_d.s0.prescale_sel   = req.wdata[PSEL_W-1:0];
        REG_S0_RELOAD:  s_d.s0.reload_value   = req.wdata;
        REG_S0_CMP:     s_d.s0.compare_value  = req.wdata;
        REG_S1_PSEL:    s_d.s1.prescale_sel   = req.wdata[PSEL_W-1:0];
        REG_S1_RELOAD:  s_d.s1.reload_value   = req.wdata;
        REG_S1_CMP:     s_d.s1.compare_value  = req.wdata;
        REG_LCD_PSEL:   s_d.lcd.prescale_sel  = req.wdata[PSEL_W-1:0];
        REG_LCD_RELOAD: s_d.lcd.reload_value  = req.wdata;
        REG_LCD_CMP:    s_d.lcd.compare_value = req.wdata;
        REG_LCD_DUTY:   s_d.duty = (req.wdata[1:0] == 2'h3) ? DUTY_1_8 : lcd_duty_t'(req.wdata[1:0]);
        default:        ;
      endcase
    end
    if (req.rd) begin
      unique case (req.addr)
        REG_S0_PSEL:    s_d.rdata = DATA_W'(s_q.s0.prescale_sel);
        REG_S0_RELOAD:  s_d.rdata = s_q.s0.reload_value;
        REG_S0_CMP:     s_d.rdata = s_q.s0.compare_value;
        REG_S1_PSEL:    s_d.rdata = DATA_W'(s_q.s1.prescale_sel);
        REG_S1_RELOAD:  s_d.rdata = s_q.s1.reload_value;
        REG_S1_CMP:     s_d.rdata = s_q.s1.compare_value;
        REG_LCD_PSEL:   s_d.rdata = DATA_W'(s_q.lcd.prescale_sel);
        REG_LCD_RELOAD: s_d.rdata = s_q.lcd.reload_value;
        REG_LCD_CMP:    s_d.rdata = s_q.lcd.compare_value;
        REG_LCD_DUTY:   s_d.rdata = DATA_W'(s_q.duty);
        REG_STATUS: begin
          s_d.rdata[STAT_S0_BIT]  = s_q.s0_clk;
          s_d.rdata[STAT_S1_BIT]  = s_q.s1_clk;
          s_d.rdata[STAT_LCD_BIT] = s_q.frame;
        end
        default:        s_d.rdata = RESET_VAL;
      endcase
    end
    if (uf0) begin
      s_d.s0_div = s_q.s0_div + 5'(1);
      s_d.s0_clk = (s_d.s0_div >= 5'(SERIAL_DIV / 2));
    end
    if (uf1) begin
      s_d.s1_div = s_q.s1_div + 5'(1);
      s_d.s1_clk = (s_d.s1_div >= 5'(SERIAL_DIV / 2));
    end
    fhalf = (s_q.duty == DUTY_1_8) ? FDIV_W'(FRAME_DIV_B / 2) : FDIV_W'(FRAME_DIV_A / 2);
    if (ufl) begin
      if (s_q.f_div == fhalf - FDIV_W'(1)) begin
        s_d.f_div = '0;
        s_d.frame = ~s_q.frame;
      end else begin
        s_d.f_div = s_q.f_div + FDIV_W'(1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign rdata           = s_q.rdata;
  assign serial0_tick    = s_q.s0_uf;
  assign serial1_tick    = s_q.s1_uf;
  assign serial0_bit_clk = s_q.s0_clk;
  assign serial1_bit_clk = s_q.s1_clk;
  assign lcd_src_tick    = s_q.lcd_uf;
  assign lcd_frame_freq  = s_q.frame;

endmodule : timer_rate_source

// *** tb/rate_source_asserts.sv ***
module rate_source_asserts
  import rate_source_pkg::*;
(
  input wire logic              clk,
  input wire logic              reset,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic              wr,
  input wire logic              rd,
  input wire logic [DATA_W-1:0] rdata,
  input wire logic              serial0_tick,
  input wire logic              serial1_tick,
  input wire logic              serial0_bit_clk,
  input wire logic              serial1_bit_clk,
  input wire logic              lcd_src_tick,
  input wire logic              lcd_frame_freq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  sequence held(s);
    s[*8];
  endsequence
  a_rd_quiet: assert property (!$past(rd) |-> rdata == 8'h00) else $error("stray rdata");
  a_unmapped_rd: assert property (rd && addr > REG_STATUS |=> rdata == 8'h00) else $error("unmapped");
  a_reset_quiet: assert property (disable iff (1'b0) reset |=> !(serial0_tick | serial1_tick
    | serial0_bit_clk | serial1_bit_clk | lcd_src_tick | lcd_frame_freq)) else $error("reset out");
  a_s0_cause: assert property ($changed(serial0_bit_clk) |-> serial0_tick
    || $past(serial0_tick) || $past(serial0_tick, 2)) else $error("s0 clock without tick");
  a_s1_cause: assert property ($changed(serial1_bit_clk) |-> serial1_tick
    || $past(serial1_tick) || $past(serial1_tick, 2)) else $error("s1 clock without tick");
  a_frame_cause: assert property ($changed(lcd_frame_freq) |-> lcd_src_tick
    || $past(lcd_src_tick) || $past(lcd_src_tick, 2)) else $error("frame without tick");
  a_s0_hold: assert property ($rose(serial0_bit_clk) |-> held(serial0_bit_clk))
    else $error("s0 clock high too short");
  a_frame_hold: assert property ($rose(lcd_frame_freq) |-> held(lcd_frame_freq))
    else $error("frame high too short");
endmodule : rate_source_asserts

// *** tb/rate_consumer.sv ***
module rate_consumer (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic src_tick,
  input  wire logic div_clk,
  output int        period,
  output int        ticks,
  output int        edges
);
  timeunit 1ns;
  timeprecision 1ps;
  int   cyc;
  int   tk;
  logic last;
  always @(posedge clk) begin
    last <= div_clk;
    cyc <= cyc + 1;
    tk <= tk + int'(src_tick);
    if (reset) begin
      edges <= 0;
    end else if (div_clk && !last) begin
      period <= cyc + 1;
      ticks <= tk + int'(src_tick);
      cyc <= 0;
      tk <= 0;
      edges <= edges + 1;
    end
  end
endmodule : rate_consumer

// *** tb/testbench.sv ***
bind timer_rate_source rate_source_asserts u_chk (.*);

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import rate_source_pkg::*;
  logic              clk;
  logic              reset;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic              wr;
  logic              rd;
  logic [DATA_W-1:0] rdata;
  logic              serial0_tick, serial1_tick, serial0_bit_clk, serial1_bit_clk;
  logic              lcd_src_tick, lcd_frame_freq;
  int                per [3];
  int                tks [3];
  int                edg [3];
  int                fail_count = 0;
  int                n_checks = 0;
  logic [31:0]       seed = 32'h2B34ADD5;
  logic [2:0]        ps [3];
  logic [7:0]        rl [3];
  logic [7:0]        v;

  timer_rate_source i_dut (.*);
  rate_consumer u_s0 (.clk, .reset, .src_tick(serial0_tick), .div_clk(serial0_bit_clk),
    .period(per[0]), .ticks(tks[0]), .edges(edg[0]));
  rate_consumer u_s1 (.clk, .reset, .src_tick(serial1_tick), .div_clk(serial1_bit_clk),
    .period(per[1]), .ticks(tks[1]), .edges(edg[1]));
  rate_consumer u_lcd (.clk, .reset, .src_tick(lcd_src_tick), .div_clk(lcd_frame_freq),
    .period(per[2]), .ticks(tks[2]), .edges(edg[2]));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk

  task automatic summarize();
    $display("checks %0d errors %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : summarize

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    wr <= 1'b1;
    rd <= 1'b0;
    addr <= a;
    wdata <= d;
    @(posedge clk);
  endtask : wr_reg

  task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
    rd <= 1'b1;
    wr <= 1'b0;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk({24'h000000, rdata}, {24'h000000, e});
    @(posedge clk);
  endtask : rd_chk

  // Waits three divided edges so a period after any config change is fully new.
  task automatic measure(input int m);
    int e [3];
    int d;
    wr <= 1'b0;
    e = edg;
    while (edg[0] < e[0] + 3 || edg[1] < e[1] + 3 || edg[2] < e[2] + 3) @(posedge clk);
    for (int k = 0; k < 3; k++) begin
      d = (k < 2) ? SERIAL_DIV : ((m == 2) ? FRAME_DIV_B : FRAME_DIV_A);
      chk(per[k], d * ((rl[k] + 1) << ps[k]));
      chk(tks[k], d);
    end
  endtask : measure

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial begin
    // At the slowest settings the whole run needs about 20k cycles; this leaves a wide margin.
    repeat (90000) @(posedge clk);
    fail_count++;
    summarize();
  end

  initial begin
    reset = 1'b1;
    addr = '0;
    wdata = '0;
    wr = 1'b0;
    rd = 1'b0;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    // No divided clock can have risen yet, so every status bit still reads low.
    rd_chk(REG_STATUS, 8'h00);
    for (int a = 0; a < 16; a++)
      if (4'(a) != REG_STATUS) rd_chk(4'(a), RESET_VAL);
    for (int m = 0; m < 3; m++) begin
      for (int k = 0; k < 3; k++) begin
        ps[k] = 3'(rnd() % (4 - k));
        rl[k] = (m == 0) ? 8'h00 : 8'(rnd() % 4);
        wr_reg(4'(3 * k), 8'(ps[k]));
        wr_reg(4'(3 * k + 1), rl[k]);
      end
      wr_reg(REG_LCD_DUTY, 8'(m));
      for (int c = 0; c < 2; c++) begin
        for (int k = 0; k < 3; k++) begin
          v = 8'(rnd());
          wr_reg(4'(3 * k + 2), v);
          rd_chk(4'(3 * k + 2), v);
          rd_chk(4'(3 * k), 8'(ps[k]));
        end
        measure(m);
      end
    end
    summarize();
  end
endmodule : testbench
